/* File: design/pecu_page_rom.sv */
`timescale 1ns/100ps
`include "pecu_regs.svh"
// Maps a page byte index onto the frozen counter snapshot
module pecu_page_rom #(
    parameter int NCNT = 7
) (
    input wire logic [9:0] idx_i,
    input wire logic [NCNT*16-1:0] ids_i,
    input wire logic [NCNT*32-1:0] vals_i,
    output logic [7:0] byte_o
);
    // Each entry: 2 identifier bytes, 4 value bytes (32-bit width code)
    localparam int ENTRY = 6;

    always_comb begin
        int rel;
        int slot;
        int off;
        rel = 0;
        slot = 0;
        off = 0;
        byte_o = 8'h00;
        if (idx_i >= `PECU_HDR_BYTES && idx_i < `PECU_CSUM_IDX) begin
            rel = int'(idx_i) - int'(`PECU_HDR_BYTES);
            slot = rel / ENTRY;
            off = rel % ENTRY;
            if (slot < NCNT) begin
                // Little-endian identifier, then value
                if (off < 2) begin
                    byte_o = ids_i[slot*16 + off*8 +: 8];
                end else begin
                    byte_o = vals_i[slot*32 + (off-2)*8 +: 8];
                end
            end
            // Past the list every byte is zero: identifier 0 ends it
        end
    end
endmodule

/* File: design/pecu_pkg.sv */
package pecu_pkg;
    // Log reader states
    typedef enum logic [1:0] {
        PECU_IDLE,
        PECU_SEND,
        PECU_CSUM
    } pecu_state_t;
endpackage

/* File: design/pecu_regs.svh */
`ifndef PECU_REGS_SVH
`define PECU_REGS_SVH
// Log page that carries the counter list
`define PECU_LOG_PAGE 8'h11
// Features bit that asks for read-and-clear
`define PECU_FEAT_CLR_BIT 0
// Identify data word and bit that flag the feature
`define PECU_ID_WORD 8'd76
`define PECU_ID_BIT 10
// Page layout
`define PECU_PAGE_BYTES 10'd512
`define PECU_HDR_BYTES 10'd4
`define PECU_CSUM_IDX 10'd511
// Identifier fields
`define PECU_ID_VENDOR_BIT 15
`define PECU_ID_WIDTH_LSB 12
`define PECU_WIDTH_16 3'h1
`define PECU_WIDTH_32 3'h2
`define PECU_WIDTH_48 3'h3
`define PECU_WIDTH_64 3'h4
// Implemented counter codes (bits 11:0)
`define PECU_CODE_CMD_ICRC 12'h001
`define PECU_CODE_RERR_DATA 12'h002
`define PECU_CODE_RERR_D2H_DATA 12'h003
`define PECU_CODE_PHY_RDY 12'h009
`define PECU_CODE_RST_SIG 12'h00a
`define PECU_CODE_RX_CRC 12'h00b
`define PECU_CODE_RX_NONCRC 12'h00d
// Terminating identifier
`define PECU_ID_END 16'h0000
// Counter reset value
`define PECU_CNT_RST 32'h0000_0000
`endif

/* File: design/pecu_sat_cnt.sv */
`timescale 1ns/100ps
`include "pecu_regs.svh"
// One saturating event counter
module pecu_sat_cnt #(
    parameter int WIDTH = 32
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic clear_i,
    input wire logic event_i,
    output logic [WIDTH-1:0] count_o
);
    // Refused at elaboration: widths outside this range cannot be reported
    if (WIDTH < 2 || WIDTH > 64) begin : g_bad_width
        $error("pecu_sat_cnt: WIDTH out of range");
    end

    // Clear wins over an event in the same cycle, since the clear marks a
    // new epoch that starts after the snapshot already taken
    always_ff @(posedge mclk_i) begin
        if (rst_i || clear_i) begin
            count_o <= '0;
        end else if (event_i && count_o != {WIDTH{1'b1}}) begin
            count_o <= count_o + 1'b1;
        end
    end
endmodule

/* File: design/pecu_top.sv */
`timescale 1ns/100ps
`include "pecu_regs.svh"
module pecu_top #(
    parameter int CNT_W = 32
) (
    input wire logic mclk_i,
    input wire logic rst_i,               // Power-on reset only
    // Event pulses from the link layer, same clock, except the asynchronous ready pin
    input wire logic cmd_done_i,          // Command completed
    input wire logic cmd_err_i,           // Status ERR bit at completion
    input wire logic cmd_icrc_i,          // Error ICRC bit at completion
    input wire logic tx_data_rerr_i,      // Sent data frame answered R_ERR
    input wire logic rx_data_rerr_i,      // Received data frame rejected R_ERR
    input wire logic rx_crc_rerr_i,       // Received frame rejected, CRC
    input wire logic rx_noncrc_rerr_i,    // Received frame rejected, other cause
    input wire logic rst_sig_ok_i,        // Reset signature frame answered R_OK
    input wire logic bist_act_i,          // BIST Activate frame received
    input wire logic phy_rdy_i,           // Physical link ready, from a pin
    // Log read request
    input wire logic log_req_i,           // One-cycle read request
    input wire logic [7:0] log_page_i,    // Requested page
    input wire logic [15:0] log_feat_i,   // Features field
    input wire logic byte_ready_i,        // Consumer takes a byte
    output logic log_busy_o,              // Page being delivered
    output logic log_nak_o,               // Request refused, other page or not idle, one-cycle pulse
    output logic byte_valid_o,            // Byte on byte_o is offered
    output logic [7:0] byte_o,            // Page byte
    output logic byte_last_o,             // Marks byte 511
    // Identify word 76 contribution
    output logic [15:0] id_word76_o
);
    localparam int NCNT = 7; // Implemented counters, one log entry each

    // The entry layout is fixed at six bytes, so only 32-bit counters fit;
    // refused while the design is elaborated, before any clock runs
    if (CNT_W != 32) begin : g_bad_cnt_w
        $error("pecu_top: only 32-bit counters are served");
    end

    // Builds an identifier: vendor bit, width code, code
    function automatic logic [15:0] mk_id(input logic [11:0] code);
        mk_id = {1'b0, `PECU_WIDTH_32, code};
    endfunction

    // Ready pin passes two flops before use. All three reset to not-ready,
    // the pin's idle level, so a link already up after power-on counts once
    // as a fresh transition into ready
    logic rdy_meta_q; // First stage, may go metastable
    logic rdy_sync_q;
    logic rdy_prev_q;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rdy_meta_q <= 1'b0;
            rdy_sync_q <= 1'b0;
            rdy_prev_q <= 1'b0;
        end else begin
            rdy_meta_q <= phy_rdy_i;
            rdy_sync_q <= rdy_meta_q;
            rdy_prev_q <= rdy_sync_q;
        end
    end

    // Rising edge of ready: not-ready to ready transition
    logic rdy_rise;
    assign rdy_rise = rdy_sync_q && !rdy_prev_q;

    // Clear request from the read-and-clear path
    logic rc_clear_q;
    logic cnt_clear;
    // Link and soft resets are not inputs here, so they cannot touch counts
    assign cnt_clear = bist_act_i || rc_clear_q;

    // Event vector, one bit per implemented counter; 008h, 00Fh, 010h,
    // 012h and 013h are deliberately absent
    logic [NCNT-1:0] evt;
    assign evt[0] = cmd_done_i && cmd_err_i && cmd_icrc_i;
    assign evt[1] = tx_data_rerr_i || rx_data_rerr_i;
    assign evt[2] = tx_data_rerr_i;
    assign evt[3] = rdy_rise;
    assign evt[4] = rst_sig_ok_i;
    assign evt[5] = rx_crc_rerr_i;
    assign evt[6] = rx_noncrc_rerr_i;

    // 002h may see a sent and a received rejection in the same cycle; it then
    // steps by two so that neither frame is lost from the total
    logic [CNT_W-1:0] rerr_step;
    logic [CNT_W-1:0] rerr_cnt_q;
    assign rerr_step = (tx_data_rerr_i && rx_data_rerr_i) ? CNT_W'(32'h2) : CNT_W'(32'h1);
    // Own saturating adder: the shared counter only steps by one
    always_ff @(posedge mclk_i) begin
        if (rst_i || cnt_clear) begin
            rerr_cnt_q <= '0;
        end else if (evt[1] && rerr_cnt_q > ~rerr_step) begin
            rerr_cnt_q <= '1;
        end else if (evt[1]) begin
            rerr_cnt_q <= rerr_cnt_q + rerr_step;
        end
    end

    // Identifier table in the chosen order; a host parses by identifier, so
    // the order only has to stay fixed within this design
    logic [NCNT*16-1:0] ids;
    assign ids = {mk_id(`PECU_CODE_RX_NONCRC), mk_id(`PECU_CODE_RX_CRC),
                  mk_id(`PECU_CODE_RST_SIG), mk_id(`PECU_CODE_PHY_RDY),
                  mk_id(`PECU_CODE_RERR_D2H_DATA), mk_id(`PECU_CODE_RERR_DATA),
                  mk_id(`PECU_CODE_CMD_ICRC)};

    // The counters themselves
    logic [NCNT*CNT_W-1:0] cnt;
    genvar g;
    generate
        for (g = 0; g < NCNT; g++) begin : g_cnt
            if (g == 1) begin : g_dual
                // 002h comes from the two-step adder above
                assign cnt[g*CNT_W +: CNT_W] = rerr_cnt_q;
            end else begin : g_single
                pecu_sat_cnt #(
                    .WIDTH(CNT_W)
                ) u_cnt (
                    .mclk_i(mclk_i),
                    .rst_i(rst_i),
                    .clear_i(cnt_clear),
                    .event_i(evt[g]),
                    .count_o(cnt[g*CNT_W +: CNT_W])
                );
            end
        end
    endgenerate

    // Snapshot frozen at request so the page stays self-consistent
    logic [NCNT*CNT_W-1:0] snap_q;
    pecu_pkg::pecu_state_t state_q;
    logic [9:0] idx_q;
    logic [7:0] sum_q;
    logic clr_after_q;
    logic [7:0] rom_byte;

    pecu_page_rom #(
        .NCNT(NCNT)
    ) u_rom (
        .idx_i(idx_q),
        .ids_i(ids),
        .vals_i(snap_q),
        .byte_o(rom_byte)
    );

    // A byte moves when offered and taken
    logic fire;
    assign fire = byte_valid_o && byte_ready_i;

    // A request is taken only when idle and the busy flag has fallen, so a
    // request in the one-cycle tail after the checksum is refused, not lost
    logic req_ok;
    assign req_ok = log_req_i && log_page_i == `PECU_LOG_PAGE &&
                    state_q == pecu_pkg::PECU_IDLE && !log_busy_o;

    // Page delivery state machine: idle, the 511 data bytes, the checksum.
    // The snapshot is frozen at the taken request; later events stay in the
    // live counters for the next page unless a read-and-clear or a self-test clear wipes them
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_q <= pecu_pkg::PECU_IDLE;
            idx_q <= 10'd0;
            sum_q <= 8'h00;
            clr_after_q <= 1'b0;
            snap_q <= '0;
        end else begin
            case (state_q)
                pecu_pkg::PECU_IDLE: begin
                    if (req_ok) begin
                        state_q <= pecu_pkg::PECU_SEND;
                        snap_q <= cnt;
                        idx_q <= 10'd0;
                        sum_q <= 8'h00;
                        clr_after_q <= log_feat_i[`PECU_FEAT_CLR_BIT];
                    end
                end
                pecu_pkg::PECU_SEND: begin
                    if (fire) begin
                        sum_q <= sum_q + byte_o;
                        idx_q <= idx_q + 10'd1;
                        if (idx_q == `PECU_CSUM_IDX - 10'd1) begin
                            state_q <= pecu_pkg::PECU_CSUM;
                        end
                    end
                end
                pecu_pkg::PECU_CSUM: begin
                    if (fire) begin
                        state_q <= pecu_pkg::PECU_IDLE;
                        idx_q <= 10'd0;
                        clr_after_q <= 1'b0;
                    end
                end
                default: begin
                    state_q <= pecu_pkg::PECU_IDLE;
                end
            endcase
        end
    end

    // Clear only after the whole page has gone out. The pulse is registered,
    // so counters clear one edge after the checksum is taken; an event in
    // that edge is lost, the price of keeping the clear off the byte path
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rc_clear_q <= 1'b0;
        end else begin
            rc_clear_q <= fire && state_q == pecu_pkg::PECU_CSUM && clr_after_q;
        end
    end

    // Output byte register, loaded for the new index one cycle after a take. The
    // checksum is formed as byte 510 is taken, from the running sum plus
    // that byte, so it is ready without waiting for another rom lookup
    logic [7:0] next_byte;
    always_comb begin
        next_byte = 8'h00;
        if (state_q == pecu_pkg::PECU_SEND) begin
            if (fire && idx_q == `PECU_CSUM_IDX - 10'd1) begin
                next_byte = 8'h00 - (sum_q + byte_o);
            end else if (fire) begin
                next_byte = byte_o;
            end else begin
                next_byte = rom_byte;
            end
        end else if (state_q == pecu_pkg::PECU_CSUM) begin
            next_byte = byte_o;
        end
    end

    // The byte register holds the byte currently offered; the rom is
    // indexed by idx_q, so after a fire we present it one cycle later
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            byte_o <= 8'h00;
            byte_valid_o <= 1'b0;
            byte_last_o <= 1'b0;
        end else if (state_q == pecu_pkg::PECU_SEND) begin
            byte_o <= fire ? next_byte : rom_byte;
            if (fire && idx_q == `PECU_CSUM_IDX - 10'd1) begin
                byte_valid_o <= 1'b1;
                byte_last_o <= 1'b1;
            end else begin
                // Drop valid for one cycle after a take so the rom settles
                byte_valid_o <= !fire;
                byte_last_o <= 1'b0;
            end
        end else if (state_q == pecu_pkg::PECU_CSUM) begin
            byte_o <= next_byte;
            byte_valid_o <= !fire;
            byte_last_o <= !fire;
        end else begin
            byte_o <= 8'h00;
            byte_valid_o <= 1'b0;
            byte_last_o <= 1'b0;
        end
    end

    // Busy flag and refusal of other pages
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            log_busy_o <= 1'b0;
            log_nak_o <= 1'b0;
        end else begin
            // Busy rises with the taken request and falls one edge after idle
            log_busy_o <= state_q != pecu_pkg::PECU_IDLE || req_ok;
            // Every request that is not taken is refused, never dropped silently
            log_nak_o <= log_req_i && !req_ok;
        end
    end

    // Identify word 76 contribution: only the feature bit
    // Other bits of the word belong to other features and stay at zero
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            id_word76_o <= 16'h0000;
        end else begin
            id_word76_o <= 16'h0001 << `PECU_ID_BIT;
        end
    end
endmodule

/* File: verif/pecu_host_model.sv */
`timescale 1ns/100ps
// Host reading the counter page; may stall every other cycle
module pecu_host_model (
    input wire logic mclk_i,
    input wire logic start_i,
    input wire logic slow_i,
    input wire logic byte_valid_o,
    input wire logic [7:0] byte_o,
    input wire logic byte_last_o,
    output logic byte_ready_i,
    output int nbytes_o,
    output int last_at_o
);
    logic [7:0] page [512]; // Captured page, read by the bench
    logic rdy_q = 1'b0;
    int cnt_q = 0;
    int last_q = 0;
    assign byte_ready_i = rdy_q;
    assign nbytes_o = cnt_q;
    assign last_at_o = last_q;
    // Ready moves just after the edge; slow mode toggles it
    always @(posedge mclk_i) begin
        rdy_q <= #1 slow_i ? ~rdy_q : 1'b1;
    end
    // Take a byte on valid and ready; the whole page is kept, the bench parses it
    always @(posedge mclk_i) begin
        if (start_i) begin
            cnt_q <= 0;
        end else if (byte_valid_o && rdy_q && cnt_q < 512) begin
            page[cnt_q] <= byte_o;
            cnt_q <= cnt_q + 1;
            if (byte_last_o) begin
                last_q <= cnt_q;
            end
        end
    end
endmodule

/* File: verif/pecu_top_asserts.sv */
`timescale 1ns/100ps
// Port-level protocol checks for the log read path and the identify word
module pecu_top_asserts #(
    parameter int CNT_W = 32
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic log_req_i,
    input wire logic [7:0] log_page_i,
    input wire logic byte_ready_i,
    input wire logic log_busy_o,
    input wire logic log_nak_o,
    input wire logic byte_valid_o,
    input wire logic [7:0] byte_o,
    input wire logic byte_last_o,
    input wire logic [15:0] id_word76_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // Bytes taken so far in the page being delivered
    logic [9:0] taken_q;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            taken_q <= 10'h000;
        end else if (byte_valid_o && byte_ready_i) begin
            taken_q <= byte_last_o ? 10'h000 : taken_q + 10'h001;
        end
    end
    // Identify bit must be up from the first edge after reset
    AST_ID_WORD: assert property (!$past(rst_i) |-> id_word76_o == 16'h0400)
        else $error("identify word wrong");
    AST_NAK_PAGE: assert property (log_req_i && log_page_i != 8'h11 |=> log_nak_o)
        else $error("foreign page not refused");
    AST_NAK_BUSY: assert property (log_req_i && log_busy_o |=> log_nak_o)
        else $error("request while busy not refused");
    AST_NAK_QUIET: assert property (log_req_i && log_page_i == 8'h11 && !log_busy_o |=> !log_nak_o)
        else $error("good request refused");
    // Accepted read offers header byte zero two edges later
    AST_ACCEPT: assert property (log_req_i && log_page_i == 8'h11 && !log_busy_o |=>
        log_busy_o ##1 (byte_valid_o && byte_o == 8'h00 && !byte_last_o))
        else $error("page start wrong");
    // A stalled byte must not move under the host
    AST_HOLD: assert property (byte_valid_o && !byte_ready_i |=>
        byte_valid_o && $stable(byte_o) && $stable(byte_last_o))
        else $error("byte changed while stalled");
    AST_GAP: assert property (byte_valid_o && byte_ready_i && !byte_last_o && taken_q != 10'h1fe |=>
        !byte_valid_o ##1 byte_valid_o)
        else $error("byte pacing wrong");
    // The checksum follows byte 510 with no idle cycle
    AST_CSUM_NEXT: assert property (byte_valid_o && byte_ready_i && taken_q == 10'h1fe |=>
        byte_valid_o && byte_last_o)
        else $error("checksum not offered after byte 510");
    AST_LAST_POS: assert property (byte_valid_o && byte_last_o |-> taken_q == 10'h1ff)
        else $error("last marker not on byte 511");
    AST_END: assert property (byte_valid_o && byte_ready_i && byte_last_o |=> !byte_valid_o ##1 !log_busy_o)
        else $error("page did not end after checksum");
    AST_VALID_BUSY: assert property (byte_valid_o |-> log_busy_o)
        else $error("byte offered while idle");
    COV_READ: cover property (log_req_i && log_page_i == 8'h11 && !log_busy_o);
    COV_NAK: cover property (log_nak_o);
    COV_STALL: cover property (byte_valid_o && !byte_ready_i);
    COV_CSUM: cover property (byte_valid_o && byte_ready_i && byte_last_o);
endmodule
bind pecu_top pecu_top_asserts #(.CNT_W(CNT_W)) i_asserts (.mclk_i(mclk_i), .rst_i(rst_i),
    .log_req_i(log_req_i), .log_page_i(log_page_i), .byte_ready_i(byte_ready_i),
    .log_busy_o(log_busy_o), .log_nak_o(log_nak_o), .byte_valid_o(byte_valid_o),
    .byte_o(byte_o), .byte_last_o(byte_last_o), .id_word76_o(id_word76_o));

/* File: verif/pecu_top_tb_top.sv */
`timescale 1ns/100ps
module pecu_top_tb_top;
    // Entry identifiers in the block's own order, width code 32 bit
    localparam logic [15:0] IDS [7] = '{16'h2001, 16'h2002, 16'h2003, 16'h2009, 16'h200a, 16'h200b, 16'h200d};
    localparam logic [31:0] ZERO [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [8:0] ev = 9'h000; // Event pulses packed, bit 8 is the self-test clear
    logic phy_rdy_i = 1'b0;
    logic log_req_i = 1'b0;
    logic [7:0] log_page_i = 8'h00;
    logic [15:0] log_feat_i = 16'h0000;
    logic slow = 1'b0;
    logic start = 1'b0;
    logic byte_ready_i, log_busy_o, log_nak_o, byte_valid_o, byte_last_o;
    logic [7:0] byte_o;
    logic [15:0] id_word76_o;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int nbytes, last_at;
    // 25 MHz clock
    always #20 mclk_i = ~mclk_i;
    pecu_top #(.CNT_W(32)) i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .cmd_done_i(ev[0]), .cmd_err_i(ev[1]),
        .cmd_icrc_i(ev[2]), .tx_data_rerr_i(ev[3]), .rx_data_rerr_i(ev[4]), .rx_crc_rerr_i(ev[5]),
        .rx_noncrc_rerr_i(ev[6]), .rst_sig_ok_i(ev[7]), .bist_act_i(ev[8]), .phy_rdy_i(phy_rdy_i),
        .log_req_i(log_req_i), .log_page_i(log_page_i), .log_feat_i(log_feat_i), .byte_ready_i(byte_ready_i),
        .log_busy_o(log_busy_o), .log_nak_o(log_nak_o), .byte_valid_o(byte_valid_o), .byte_o(byte_o),
        .byte_last_o(byte_last_o), .id_word76_o(id_word76_o));
    pecu_host_model i_host (.mclk_i(mclk_i), .start_i(start), .slow_i(slow), .byte_valid_o(byte_valid_o),
        .byte_o(byte_o), .byte_last_o(byte_last_o), .byte_ready_i(byte_ready_i), .nbytes_o(nbytes),
        .last_at_o(last_at));
    task automatic end_of_test();
        if (fail_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Guard against a hang: the reads need about 7300 cycles
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One event cycle, then a quiet one, so calls in a row never drive twice in a time step
    task automatic pulse(input logic [8:0] v);
        ev = v;
        @(posedge mclk_i);
        #1 ev = 9'h000;
        @(posedge mclk_i);
        #1;
    endtask
    task automatic request(input logic [7:0] pg, input logic [15:0] ft);
        log_req_i = 1'b1;
        log_page_i = pg;
        log_feat_i = ft;
        @(posedge mclk_i);
        #1 log_req_i = 1'b0;
    endtask
    // Wait for a whole page, then parse it against the expected counts
    task automatic collect(input logic [31:0] exp [7]);
        logic [7:0] sum;
        int k;
        sum = 8'h00;
        k = 0;
        while (nbytes < 512 && k < 4000) begin
            @(posedge mclk_i);
            k++;
        end
        check(nbytes, 512);
        check(last_at, 511);
        for (int i = 0; i < 512; i++) begin
            sum += i_host.page[i];
            if (i < 4 || (i >= 46 && i < 511)) check(i_host.page[i], 8'h00);
        end
        check(sum, 8'h00);
        for (int e = 0; e < 7; e++) begin
            check({i_host.page[5+6*e], i_host.page[4+6*e]}, IDS[e]);
            check({i_host.page[9+6*e], i_host.page[8+6*e], i_host.page[7+6*e], i_host.page[6+6*e]}, exp[e]);
        end
        repeat (3) @(posedge mclk_i);
        #1 check(log_busy_o, 1'b0);
    endtask
    task automatic read_page(input logic [15:0] ft, input logic [31:0] exp [7]);
        start = 1'b1;
        @(posedge mclk_i);
        #1 start = 1'b0;
        request(8'h11, ft);
        check(log_nak_o, 1'b0);
        collect(exp);
    endtask
    // Each event kind, with partial command errors that must not count
    task automatic t_count();
        repeat (2) pulse(9'h007);
        pulse(9'h003);
        pulse(9'h005);
        pulse(9'h006);
        repeat (2) pulse(9'h008);
        pulse(9'h010);
        pulse(9'h018);
        repeat (3) pulse(9'h020);
        pulse(9'h040);
        pulse(9'h080);
        phy_rdy_i = 1'b1;
        repeat (6) @(posedge mclk_i);
        #1 read_page(16'h0000, '{32'd2, 32'd5, 32'd3, 32'd1, 32'd1, 32'd3, 32'd1});
    endtask
    // Read-and-clear under a stalling host: values first, zeros after
    task automatic t_read_clear();
        slow = 1'b1;
        read_page(16'h0001, '{32'd2, 32'd5, 32'd3, 32'd1, 32'd1, 32'd3, 32'd1});
        slow = 1'b0;
        read_page(16'h0000, ZERO);
    endtask
    // Foreign page and a second request mid-delivery are both refused
    task automatic t_refuse();
        request(8'h10, 16'h0000);
        check(log_nak_o, 1'b1);
        start = 1'b1;
        @(posedge mclk_i);
        #1 start = 1'b0;
        // Request held over two edges: the first is taken, the second refused
        log_req_i = 1'b1;
        log_page_i = 8'h11;
        log_feat_i = 16'h0000;
        @(posedge mclk_i);
        #1 check(log_nak_o, 1'b0);
        @(posedge mclk_i);
        #1 log_req_i = 1'b0;
        check(log_nak_o, 1'b1);
        collect(ZERO);
    endtask
    // Self-test clear, also when it meets every event pulse but the link-ready rise in the same cycle
    task automatic t_bist();
        pulse(9'h0ff);
        pulse(9'h100);
        read_page(16'h0000, ZERO);
        pulse(9'h1ff);
        read_page(16'h0000, ZERO);
    endtask
    initial begin
        repeat (16) @(posedge mclk_i);
        #1 rst_i = 1'b0;
        @(posedge mclk_i);
        #1 check(id_word76_o, 16'h0400);
        read_page(16'h0000, ZERO);
        t_count();
        t_read_clear();
        t_refuse();
        t_bist();
        end_of_test();
    end
endmodule
